// ===== src/maf_pkg.sv
// package for the station address, group hash filter and logic reset block
// assumes a 32-bit apb slave on core_clk at 200 mhz
package maf_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_RESET_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATION_LOW    = 8'h04;
    localparam logic [7:0] OFF_STATION_HIGH   = 8'h08;
    localparam logic [7:0] OFF_HASH_LOW       = 8'h0C;
    localparam logic [7:0] OFF_HASH_HIGH      = 8'h10;
    localparam logic [7:0] OFF_FILTER_QUERY   = 8'h14;
    localparam logic [7:0] OFF_FILTER_RESULT  = 8'h18;
    // field positions
    localparam int RESET_BIT       = 0;
    localparam int ADDR_BITS       = 48;
    localparam int HASH_BITS       = 6;
    localparam int HASH_WORD       = 32;
    localparam int RESULT_HIT_BIT  = 8;
    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // soft reset pulse length in cycles
    localparam logic [3:0] LOGIC_RESET_CYCLES = 4'h4;
    // reset sequencer states
    typedef enum logic [1:0] {
        MAF_IDLE,
        MAF_WAIT_DMA,
        MAF_PULSE
    } maf_rst_state_t;
endpackage

// ===== src/maf_hash.sv
// xor-fold hash of a 48-bit destination address
// pure combinational; the caller registers the result
`timescale 1ns/1ps
module maf_hash
(
    input  wire logic [47:0] destination_address, // address to fold
    output logic      [5:0]  hash_index           // 6-bit table index
);
    // bit i is the xor of address bits i, i+6, ... i+42
    // R7: fold address bits
    always_comb
    begin
        hash_index = 6'h00;
        for (int k = 0; k < maf_pkg::ADDR_BITS / maf_pkg::HASH_BITS; k++)
        begin
            hash_index = hash_index ^
                destination_address[k*maf_pkg::HASH_BITS +:
                                    maf_pkg::HASH_BITS];
        end
    end
endmodule

// ===== src/maf_lookup.sv
// selects one bit of the 64-bit group hash table
// pure combinational; table halves come from registers
`timescale 1ns/1ps
module maf_lookup
(
    input  wire logic [31:0] table_low,  // hash values 0 to 31
    input  wire logic [31:0] table_high, // hash values 32 to 63
    input  wire logic [5:0]  hash_index, // selected entry
    output logic             hit         // entry is set
);
    // upper index bit picks the half, low five bits pick the position
    always_comb
    begin
        // R8: select table bit
        if (hash_index[5])
        begin
            // R11: high half, bit = hash - 32
            hit = table_high[hash_index[4:0]];
        end
        else
        begin
            // R9: low half, bit = hash
            hit = table_low[hash_index[4:0]];
        end
    end
endmodule

// ===== src/maf_top.sv
// station address, group hash filter and software logic reset for a mac
// Behaviour
// R1: writing one resets the mac logic
// R2: reset waits for both dma engines idle
// R3: reset bit reads one until reset done
// R4: software polls bit until it reads zero
// R5: low register holds bytes zero and one
// R6: high register holds bytes two to five
// R7: six-bit xor fold of destination address
// R8: hash index selects one table bit
// R9: low table covers hashes 0 to 31
// R10: accept group frame when bit set
// R11: high table covers hashes 32 to 63
// R12: reject group frame when bit clear
// assumes an apb master on core_clk and dma idle levels on the same clock
`timescale 1ns/1ps
module maf_top
(
    input  wire logic        core_clk,            // 200 mhz clock
    input  wire logic        rst,                 // sync reset, high
    input  wire logic        psel,                // apb select
    input  wire logic        penable,             // apb access phase
    input  wire logic        pwrite,              // apb direction
    input  wire logic [7:0]  paddr,               // apb byte address
    input  wire logic [31:0] pwdata,              // apb write data
    output logic      [31:0] prdata,              // apb read data
    output logic             pready,              // apb ready
    output logic             pslverr,             // apb error
    input  wire logic        rx_dma_idle,         // receive dma idle
    input  wire logic        tx_dma_idle,         // transmit dma idle
    input  wire logic        frame_valid,         // frame address strobe
    input  wire logic        frame_is_group,      // destination is group
    input  wire logic [47:0] destination_address, // frame destination
    output logic             frame_accept,        // group frame accepted
    output logic             frame_accept_valid,  // accept decision strobe
    output logic             mac_logic_reset,     // reset to mac logic
    output logic [47:0]      station_address      // own address
);
    logic [7:0]  station_byte0;            // address bits 7-0
    logic [7:0]  station_byte1;            // address bits 15-8
    logic [7:0]  station_byte2;            // address bits 23-16
    logic [7:0]  station_byte3;            // address bits 31-24
    logic [7:0]  station_byte4;            // address bits 39-32
    logic [7:0]  station_byte5;            // address bits 47-40
    logic [31:0] group_hash_table_low;     // hashes 0 to 31
    logic [31:0] group_hash_table_high;    // hashes 32 to 63
    logic [47:0] query_address;            // software test address
    logic [5:0]  query_hash;               // hash of test address
    logic        query_hit;                // table hit for test address
    logic [5:0]  frame_hash;               // hash of frame address
    logic        frame_hit;                // table hit for frame
    logic        logic_reset_request;      // pending soft reset
    logic [3:0]  pulse_count;              // reset pulse counter
    logic        wr_en;                    // apb write this edge
    maf_pkg::maf_rst_state_t rst_state;    // reset sequencer state
    maf_pkg::maf_rst_state_t next_rst_state;

    // a completed apb access phase
    function automatic logic apb_done(input logic s, input logic e);
        apb_done = s & e;
    endfunction

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = apb_done(psel, penable) & pwrite;

    // unmapped addresses answer with an error and read zero
    always_comb
    begin
        case (paddr)
            maf_pkg::OFF_RESET_CTRL,
            maf_pkg::OFF_STATION_LOW,
            maf_pkg::OFF_STATION_HIGH,
            maf_pkg::OFF_HASH_LOW,
            maf_pkg::OFF_HASH_HIGH,
            maf_pkg::OFF_FILTER_QUERY,
            maf_pkg::OFF_FILTER_RESULT: pslverr = 1'b0;
            default:                    pslverr = apb_done(psel, penable);
        endcase
    end

    // station address bytes; writes land only at the access edge
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            station_byte0 <= 8'h00;
            station_byte1 <= 8'h00;
            station_byte2 <= 8'h00;
            station_byte3 <= 8'h00;
            station_byte4 <= 8'h00;
            station_byte5 <= 8'h00;
        end
        else if (wr_en && paddr == maf_pkg::OFF_STATION_LOW)
        begin
            // R5: byte 0 in 15-8, byte 1 in 7-0
            station_byte0 <= pwdata[15:8];
            station_byte1 <= pwdata[7:0];
        end
        else if (wr_en && paddr == maf_pkg::OFF_STATION_HIGH)
        begin
            // R6: bytes 2..5 from top lane down
            station_byte2 <= pwdata[31:24];
            station_byte3 <= pwdata[23:16];
            station_byte4 <= pwdata[15:8];
            station_byte5 <= pwdata[7:0];
        end
    end

    // address assembled with byte 0 as the least significant byte
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            station_address <= 48'h0000_0000_0000;
        end
        else
        begin
            station_address <= {station_byte5, station_byte4, station_byte3,
                                station_byte2, station_byte1, station_byte0};
        end
    end

    // hash table halves and the software test address
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            group_hash_table_low  <= maf_pkg::REG_RESET;
            group_hash_table_high <= maf_pkg::REG_RESET;
            query_address         <= 48'h0000_0000_0000;
        end
        else if (wr_en)
        begin
            case (paddr)
                maf_pkg::OFF_HASH_LOW:     group_hash_table_low  <= pwdata;
                maf_pkg::OFF_HASH_HIGH:    group_hash_table_high <= pwdata;
                // test address low word; upper 16 bits keep their value
                maf_pkg::OFF_FILTER_QUERY: query_address[31:0]   <= pwdata;
                // writing the result word sets the upper test bits
                maf_pkg::OFF_FILTER_RESULT:
                    query_address[47:32] <= pwdata[31:16];
                default:                   ;
            endcase
        end
    end

    // reset sequencer: request, wait for dma idle, pulse, clear
    always_comb
    begin
        next_rst_state = rst_state;
        case (rst_state)
            maf_pkg::MAF_IDLE:
            begin
                if (wr_en && paddr == maf_pkg::OFF_RESET_CTRL &&
                    pwdata[maf_pkg::RESET_BIT])
                begin
                    next_rst_state = maf_pkg::MAF_WAIT_DMA;
                end
            end
            maf_pkg::MAF_WAIT_DMA:
            begin
                // R2: hold off until both dma idle
                if (rx_dma_idle && tx_dma_idle)
                begin
                    next_rst_state = maf_pkg::MAF_PULSE;
                end
            end
            maf_pkg::MAF_PULSE:
            begin
                if (pulse_count == maf_pkg::LOGIC_RESET_CYCLES - 4'h1)
                begin
                    next_rst_state = maf_pkg::MAF_IDLE;
                end
            end
            default: next_rst_state = maf_pkg::MAF_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rst_state <= maf_pkg::MAF_IDLE;
        end
        else
        begin
            rst_state <= next_rst_state;
        end
    end

    // pulse length counter runs only while the reset is driven
    always_ff @(posedge core_clk)
    begin
        if (rst || rst_state != maf_pkg::MAF_PULSE)
        begin
            pulse_count <= 4'h0;
        end
        else
        begin
            pulse_count <= pulse_count + 4'h1;
        end
    end

    // pending flag and reset output, both registered
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            logic_reset_request <= 1'b0;
            mac_logic_reset     <= 1'b0;
        end
        else
        begin
            // R3: bit high while reset pending
            logic_reset_request <= (next_rst_state != maf_pkg::MAF_IDLE);
            // R1: drive mac logic reset
            mac_logic_reset     <= (next_rst_state == maf_pkg::MAF_PULSE);
        end
    end

    // hashing of the live frame and of the software test address
    maf_hash u_frame_hash
    (
        .destination_address (destination_address),
        .hash_index          (frame_hash)
    );

    maf_hash u_query_hash
    (
        .destination_address (query_address),
        .hash_index          (query_hash)
    );

    maf_lookup u_frame_lookup
    (
        .table_low  (group_hash_table_low),
        .table_high (group_hash_table_high),
        .hash_index (frame_hash),
        .hit        (frame_hit)
    );

    maf_lookup u_query_lookup
    (
        .table_low  (group_hash_table_low),
        .table_high (group_hash_table_high),
        .hash_index (query_hash),
        .hit        (query_hit)
    );

    // accept decision one cycle after the frame strobe; the filter is
    // held quiet from the second cycle of a soft reset to the first cycle after it; a strobe sampled as it starts still decides
    always_ff @(posedge core_clk)
    begin
        if (rst || mac_logic_reset)
        begin
            frame_accept       <= 1'b0;
            frame_accept_valid <= 1'b0;
        end
        else
        begin
            frame_accept_valid <= frame_valid & frame_is_group;
            // R10: accept when bit set
            // R12: reject when bit clear
            frame_accept <= frame_valid & frame_is_group & frame_hit;
        end
    end

    // read mux, registered so prdata comes from flip-flops; apb samples
    // it in the access cycle, so the value is latched at setup
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prdata <= maf_pkg::REG_RESET;
        end
        else if (psel && !penable)
        begin
            case (paddr)
                // R4: software polls this bit
                maf_pkg::OFF_RESET_CTRL:
                    prdata <= {31'h0, logic_reset_request};
                maf_pkg::OFF_STATION_LOW:
                    prdata <= {16'h0000, station_byte0, station_byte1};
                maf_pkg::OFF_STATION_HIGH:
                    prdata <= {station_byte2, station_byte3,
                               station_byte4, station_byte5};
                maf_pkg::OFF_HASH_LOW:     prdata <= group_hash_table_low;
                maf_pkg::OFF_HASH_HIGH:    prdata <= group_hash_table_high;
                maf_pkg::OFF_FILTER_QUERY: prdata <= query_address[31:0];
                maf_pkg::OFF_FILTER_RESULT:
                    prdata <= {query_address[47:32], 7'h00, query_hit,
                               2'h0, query_hash};
                default:                   prdata <= maf_pkg::REG_RESET;
            endcase
        end
    end

    // soft reset never starts while a dma engine is busy
    a_reset_dma_idle: assert property (@(posedge core_clk) disable iff (rst)
        $rose(mac_logic_reset) |-> $past(rx_dma_idle) && $past(tx_dma_idle))
        else $error("logic reset began with dma busy"); // R2

    // request bit reads one in the cycle after the write
    a_request_pending: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && paddr == maf_pkg::OFF_RESET_CTRL &&
        pwdata[maf_pkg::RESET_BIT] && !logic_reset_request |=>
        logic_reset_request)
        else $error("reset request not shown pending"); // R3

    // pulse lasts exactly four cycles then request clears
    a_pulse_length: assert property (@(posedge core_clk) disable iff (rst)
        $rose(mac_logic_reset) |-> mac_logic_reset[*4] ##1
        (!mac_logic_reset && !logic_reset_request))
        else $error("logic reset pulse length wrong"); // R1

    // waiting request does not pulse the reset until dma idle
    a_wait_holds: assert property (@(posedge core_clk) disable iff (rst)
        logic_reset_request && !mac_logic_reset && !(rx_dma_idle &&
        tx_dma_idle) |=> !mac_logic_reset)
        else $error("reset pulsed without dma idle"); // R2

    // station low word layout
    a_station_low: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && paddr == maf_pkg::OFF_STATION_LOW |=> ##1
        station_address[15:0] ==
        {$past(pwdata[7:0], 2), $past(pwdata[15:8], 2)})
        else $error("station low bytes misplaced"); // R5

    // station high word layout, byte 5 on top
    a_station_high: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && paddr == maf_pkg::OFF_STATION_HIGH |=> ##1
        station_address[47:16] ==
        {$past(pwdata[7:0], 2), $past(pwdata[15:8], 2),
         $past(pwdata[23:16], 2), $past(pwdata[31:24], 2)})
        else $error("station high bytes misplaced"); // R6

    // accept follows the table bit for group frames
    a_accept_set: assert property (@(posedge core_clk)
        disable iff (rst || mac_logic_reset)
        frame_valid && frame_is_group && !mac_logic_reset |=>
        frame_accept == $past(frame_hit) && frame_accept_valid)
        else $error("accept does not follow table bit"); // R10

    // the hash of address bit 0 alone is index 1
    a_hash_single: assert property (@(posedge core_clk) disable iff (rst)
        destination_address == 48'h0000_0000_0001 |-> frame_hash == 6'h01)
        else $error("hash fold wrong"); // R7

    // clear bit never accepts
    a_reject_clear: assert property (@(posedge core_clk) disable iff (rst)
        frame_valid && !frame_hit |=> !frame_accept)
        else $error("frame accepted with clear bit"); // R12
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the station address, group hash filter and reset
// assumes a zero-wait apb slave and registered filter and reset outputs
`timescale 1ns/1ps
module tb_top;
    // one row: address, write data, read-back, slave error
    typedef struct packed
    {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } maf_row_t;

    logic        core_clk;            // 200 mhz clock
    logic        rst;                 // sync reset, high
    logic        psel;                // apb select
    logic        penable;             // apb access phase
    logic        pwrite;              // apb direction
    logic [7:0]  paddr;               // apb address
    logic [31:0] pwdata;              // apb write data
    logic [31:0] prdata;              // apb read data
    logic        pready;              // apb ready
    logic        pslverr;             // apb error
    logic        rx_dma_idle;         // receive dma idle
    logic        tx_dma_idle;         // transmit dma idle
    logic        frame_valid;         // frame strobe
    logic        frame_is_group;      // group destination
    logic [47:0] destination_address; // frame destination
    logic        frame_accept;        // filter hit
    logic        frame_accept_valid;  // decision strobe
    logic        mac_logic_reset;     // reset to mac logic
    logic [47:0] station_address;     // own address
    int          errors;              // mismatches
    int          checks_done;         // comparisons
    int          cycles;              // timeout count
    int          n;                   // wait count
    int          high;                // reset pulse length
    logic [31:0] rd;                  // last read data
    logic        re;                  // last slave error
    logic        hit;                 // expected filter result
    maf_row_t    rows [7];            // register cases
    logic [47:0] das [8];             // destination cases
    // table halves as programmed by the third and fourth rows
    localparam logic [63:0] TBL = 64'h0F0F_F0F0_A5A5_5A5A;

    maf_top dut
    (
        .core_clk            (core_clk),
        .rst                 (rst),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .rx_dma_idle         (rx_dma_idle),
        .tx_dma_idle         (tx_dma_idle),
        .frame_valid         (frame_valid),
        .frame_is_group      (frame_is_group),
        .destination_address (destination_address),
        .frame_accept        (frame_accept),
        .frame_accept_valid  (frame_accept_valid),
        .mac_logic_reset     (mac_logic_reset),
        .station_address     (station_address)
    );

    // free-running clock, 5 ns period
    always #2.5 core_clk = ~core_clk;

    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            errors = errors + 1;
            results();
        end
    end

    // bench model of the six-bit xor fold
    function automatic logic [5:0] fold(input logic [47:0] da);
        logic [5:0] h;
        begin
            h = 6'h00;
            for (int k = 0; k < 8; k++)
                h = h ^ da[k*6 +: 6];
            return h;
        end
    endfunction

    // compare and count; case inequality so unknowns fail
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            // hold everything until ready is seen at an edge
            // no wait limit here: the hang guard ends a stuck transfer
            while (pready !== 1'b1)
            begin
                @(posedge core_clk);
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // idle edge so the next call never reassigns in this step
            @(posedge core_clk);
        end
    endtask

    // counts then verdict; the only way the run ends
    task automatic results();
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, frame_valid, frame_is_group} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rx_dma_idle = 1'b1;
        tx_dma_idle = 1'b1;
        destination_address = 48'h0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        // reserved upper half, byte lanes, both table halves, a hole
        rows = '{'{8'h04, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0},
                 '{8'h08, 32'h0123_4567, 32'h0123_4567, 1'b0},
                 '{8'h0C, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
                 '{8'h10, 32'h0F0F_F0F0, 32'h0F0F_F0F0, 1'b0},
                 '{8'h1C, 32'hDEAD_BEEF, 32'h0000_0000, 1'b1},
                 '{8'h04, 32'h0000_1122, 32'h0000_1122, 1'b0},
                 '{8'h08, 32'h3344_5566, 32'h3344_5566, 1'b0}};
        // hashes 0, 1, 63, 32, 31, 63, 32 and a mixed one
        das = '{48'h0, 48'h1, 48'h3F, 48'h20, 48'h1F, 48'h0FC0,
                48'h8000_0000_0000, 48'h0123_4567_89AB};
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);

        // register rows: write, then read back
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w, rd, re);
            chk(48'(re), 48'(rows[i].e));
            apb(1'b0, rows[i].a, 32'h0, rd, re);
            chk(48'(rd), 48'(rows[i].r));
            chk(48'(re), 48'(rows[i].e));
        end
        // byte lanes land in the own address, byte 0 lowest
        @(negedge core_clk);
        chk(station_address, 48'h6655_4433_2211);
        @(posedge core_clk);
        $display("test registers done");

        // group frames against the programmed table
        foreach (das[i])
        begin
            hit = TBL[fold(das[i])];
            frame_valid <= 1'b1;
            frame_is_group <= 1'b1;
            destination_address <= das[i];
            @(posedge core_clk);
            frame_valid <= 1'b0;
            @(negedge core_clk);
            chk(48'(frame_accept), 48'(hit));
            chk(48'(frame_accept_valid), 48'h1);
            @(posedge core_clk);
            apb(1'b1, 8'h14, das[i][31:0], rd, re);
            apb(1'b1, 8'h18, {das[i][47:32], 16'h0000}, rd, re);
            apb(1'b0, 8'h18, 32'h0, rd, re);
            chk(48'(rd), 48'({das[i][47:32], 7'h00, hit, 2'b00,
                             fold(das[i])}));
        end
        // individual frame: no decision strobe
        frame_valid <= 1'b1;
        frame_is_group <= 1'b0;
        @(posedge core_clk);
        frame_valid <= 1'b0;
        @(negedge core_clk);
        chk(48'(frame_accept_valid), 48'h0);
        @(posedge core_clk);
        $display("test filter done");

        // second hard reset mid-run: the first five registers and the own address back to zero
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b0, 8'(k * 4), 32'h0, rd, re);
            chk(48'(rd), 48'h0);
        end
        chk(station_address, 48'h0);
        $display("test reset values done");

        // soft reset held off until both dma engines are idle
        rx_dma_idle <= 1'b0;
        tx_dma_idle <= 1'b0;
        @(posedge core_clk);
        apb(1'b1, 8'h00, 32'h0000_0001, rd, re);
        apb(1'b0, 8'h00, 32'h0, rd, re);
        chk(48'(rd), 48'h1);
        rx_dma_idle <= 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk(48'(mac_logic_reset), 48'h0);
        @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0, rd, re);
        chk(48'(rd), 48'h1);
        tx_dma_idle <= 1'b1;
        n = 0;
        high = 0;
        @(negedge core_clk);
        while (mac_logic_reset !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(negedge core_clk);
        end
        while (mac_logic_reset === 1'b1 && high < 20)
        begin
            high = high + 1;
            @(negedge core_clk);
        end
        chk(48'(high), 48'(maf_pkg::LOGIC_RESET_CYCLES));
        @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0, rd, re);
        chk(48'(rd), 48'h0);
        $display("test soft reset done");
        results();
    end
endmodule
